// file: logic/bss_sequencer.sv
// boot startup sequencer top
`timescale 1ns/1ps
module bss_sequencer import bss_pkg::*; #(
    parameter int STEP_CYCLES = STEP_CYC
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire bss_cause_s  reset_cause_reg,
    input  wire bss_cfg_s    config_sector,
    input  wire logic [31:0] key_page [KEY_PAGES][2],
    input  wire logic        host_sync,
    input  wire logic        loader_exit,
    input  wire logic        key_write_cmd,
    input  wire logic [1:0]  key_write_sel,
    input  wire bss_ack_s    test_ack,
    input  wire bss_ack_s    fill_ack,
    input  wire bss_ack_s    trim_ack,
    input  wire bss_ack_s    cal_ack,
    output logic             window_watchdog_en,
    output logic             window_watchdog_long,
    output logic             window_watchdog_lock,
    output logic             test_start,
    output logic             test_partial,
    output logic             fill_start,
    output logic             trim_start,
    output logic             trim_backup,
    output logic             cal_start,
    output logic [1:0]       nvm_protect_status,
    output logic             ram_mode_on,
    output logic             mem_mode_on,
    output logic             key_write_en,
    output logic [1:0]       key_write_mask,
    output logic [7:0]       loader_idle_count,
    output logic [7:0]       loader_node_addr,
    output logic             loader_window,
    output logic             user_run,
    output logic             debug_run,
    output logic             safe_mode,
    output logic             sleep_req,
    output logic [5:0]       error_status,
    output bss_class_e       reset_class,
    output logic [2:0]       wd_reset_count
);
    initial begin
        if (STEP_CYCLES < 1) $error("STEP_CYCLES must be positive");
    end

    bss_state_e state_reg;
    logic [$clog2(STEP_CYCLES+1)-1:0] step_cnt_reg;
    logic [7:0]  steps_left_reg;
    logic        go_reg;
    logic        cold_reg;
    logic        warm_reg;
    logic        do_test_reg;
    logic        do_fill_reg;
    logic        forever_reg;
    logic [2:0]  wd_cnt_reg;

    logic        ram_hit;
    logic        mem_hit;
    logic        idle_valid;
    bss_class_e  class_next;

    // priority picks the most thorough flow when causes overlap
    always_comb begin
        if (reset_cause_reg.cold || reset_cause_reg.wdog) begin
            class_next = BSS_COLD;
        end else if (reset_cause_reg.warm) begin
            class_next = BSS_WARM;
        end else begin
            class_next = BSS_HOT;
        end
    end

    always_comb begin
        ram_hit = 1'b0;
        mem_hit = 1'b0;
        for (int p = 0; p < KEY_PAGES; p++) begin
            ram_hit = ram_hit | (key_page[p][0] == RAM_KEY);
            mem_hit = mem_hit | (key_page[p][1] == MEM_KEY);
        end
    end

    assign idle_valid = config_sector.idle_ok &&
                        (config_sector.idle_count == IDLE_NONE ||
                         config_sector.idle_count == IDLE_FOREVER ||
                         (config_sector.idle_count >= IDLE_MIN &&
                          config_sector.idle_count <= IDLE_MAX));

    // one-cycle go pulse after release so config is sampled clocked
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            go_reg <= 1'b0;
        end else begin
            go_reg <= (state_reg == ST_CLASS) && !go_reg;
        end
    end

    // prior count must be kept outside; lost on reset_n
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wd_cnt_reg <= 3'h0;
        end else if (go_reg) begin
            wd_cnt_reg <= reset_cause_reg.wdog ? 3'(wd_reset_count + 3'h1) : 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_CLASS;
            reset_class <= BSS_COLD;
            cold_reg <= 1'b0;
            warm_reg <= 1'b0;
            do_test_reg <= 1'b0;
            do_fill_reg <= 1'b0;
            forever_reg <= 1'b0;
            window_watchdog_en <= 1'b1;
            window_watchdog_long <= 1'b1;
            window_watchdog_lock <= 1'b0;
            test_start <= 1'b0;
            test_partial <= 1'b0;
            fill_start <= 1'b0;
            trim_start <= 1'b0;
            trim_backup <= 1'b0;
            cal_start <= 1'b0;
            nvm_protect_status <= SIZE_DEFAULT;
            ram_mode_on <= 1'b0;
            mem_mode_on <= 1'b0;
            loader_idle_count <= IDLE_FOREVER;
            loader_node_addr <= NODE_BCAST;
            loader_window <= 1'b0;
            user_run <= 1'b0;
            debug_run <= 1'b0;
            safe_mode <= 1'b0;
            sleep_req <= 1'b0;
            error_status <= 6'h00;
            step_cnt_reg <= '0;
            steps_left_reg <= 8'h00;
        end else begin
            test_start <= 1'b0;
            fill_start <= 1'b0;
            trim_start <= 1'b0;
            cal_start  <= 1'b0;
            case (state_reg)
                ST_CLASS: begin
                    if (go_reg) begin
                        reset_class <= class_next;
                        cold_reg    <= class_next == BSS_COLD;
                        warm_reg    <= class_next == BSS_WARM;
                        do_test_reg <= class_next == BSS_COLD ||
                            (class_next == BSS_WARM && config_sector.test_cfg[MT_WARM]) ||
                            (class_next == BSS_HOT && config_sector.test_cfg[MT_HOT]);
                        do_fill_reg <= class_next != BSS_HOT;
                        test_partial <= class_next == BSS_COLD &&
                                        config_sector.test_cfg[MT_PART];
                        state_reg   <= ST_WDOG;
                    end
                end
                ST_WDOG: begin
                    window_watchdog_en   <= 1'b1;
                    window_watchdog_long <= 1'b1;
                    if (wd_cnt_reg >= 3'(WD_RST_MAX)) begin
                        sleep_req <= 1'b1;
                        state_reg <= ST_SLEEP;
                    end else if (do_test_reg) begin
                        test_start <= 1'b1;
                        state_reg  <= ST_TEST;
                    end else if (do_fill_reg) begin
                        fill_start <= 1'b1;
                        state_reg  <= ST_FILL;
                    end else begin
                        state_reg <= ST_CFG;
                    end
                end
                ST_TEST: begin
                    if (test_ack.done) begin
                        if (test_ack.fail) begin
                            error_status[ER_TEST] <= 1'b1;
                            state_reg <= ST_LOOP;
                        end else begin
                            fill_start <= 1'b1;
                            state_reg  <= ST_FILL;
                        end
                    end
                end
                ST_FILL: begin
                    if (fill_ack.done) begin
                        if (fill_ack.fail) begin
                            error_status[ER_FILL] <= 1'b1;
                            state_reg <= ST_LOOP;
                        end else begin
                            state_reg <= ST_CFG;
                        end
                    end
                end
                ST_CFG: begin
                    nvm_protect_status <= (config_sector.loader_size == SIZE_BLANK ||
                        config_sector.size_ecc2) ? SIZE_DEFAULT
                        : config_sector.loader_size[1:0];
                    ram_mode_on <= config_sector.key_en && ram_hit;
                    mem_mode_on <= config_sector.key_en && mem_hit;
                    loader_idle_count <= idle_valid ? config_sector.idle_count
                                                    : IDLE_FOREVER;
                    loader_node_addr <= config_sector.node_ok ? config_sector.node_addr
                                                              : NODE_BCAST;
                    if (config_sector.csum_err) begin
                        error_status[ER_CSUM] <= 1'b1;
                        state_reg <= ST_LOOP;
                    end else if (cold_reg || warm_reg) begin
                        trim_start <= 1'b1;
                        state_reg  <= ST_TRIM;
                    end else begin
                        state_reg <= ST_WIN;
                    end
                end
                ST_TRIM: begin
                    if (trim_ack.done) begin
                        if (trim_ack.fail && !trim_backup) begin
                            error_status[ER_TRIM] <= 1'b1;
                            trim_backup <= 1'b1;
                            trim_start  <= 1'b1;
                        end else if (trim_ack.fail) begin
                            state_reg <= config_sector.user_boot ? ST_SAFE : ST_LOOP;
                        end else if (config_sector.cal_cfg == CAL_ON) begin
                            cal_start <= 1'b1;
                            state_reg <= ST_CAL;
                        end else begin
                            state_reg <= ST_WIN;
                        end
                    end
                end
                ST_CAL: begin
                    if (cal_ack.done) begin
                        state_reg <= ST_WIN;
                    end
                end
                ST_WIN: begin
                    steps_left_reg <= loader_idle_count;
                    forever_reg    <= loader_idle_count == IDLE_FOREVER;
                    step_cnt_reg   <= '0;
                    if (config_sector.debug_req) begin
                        window_watchdog_en <= 1'b0;
                        debug_run <= 1'b1;
                        state_reg <= ST_DEBUG;
                    end else if (loader_idle_count == IDLE_FOREVER) begin
                        window_watchdog_en <= 1'b0;
                        loader_window <= 1'b1;
                        state_reg <= ST_HOLD;
                    end else if (loader_idle_count == IDLE_NONE) begin
                        state_reg <= ST_USER;
                    end else begin
                        loader_window <= 1'b1;
                        state_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (host_sync && window_watchdog_en) begin
                        window_watchdog_en <= 1'b0;
                        forever_reg <= 1'b1;
                    end else if (loader_exit && forever_reg) begin
                        loader_window <= 1'b0;
                        state_reg <= ST_USER;
                    end else if (!forever_reg) begin
                        if (step_cnt_reg == ($bits(step_cnt_reg))'(STEP_CYCLES - 1)) begin
                            step_cnt_reg   <= '0;
                            steps_left_reg <= steps_left_reg - 8'h01;
                            if (steps_left_reg == 8'h01) begin
                                loader_window <= 1'b0;
                                state_reg <= ST_USER;
                            end
                        end else begin
                            step_cnt_reg <= step_cnt_reg + 1'b1;
                        end
                    end
                end
                ST_USER: begin
                    if (config_sector.reset_vec == ADDR_BLANK) begin
                        error_status[ER_ADDR] <= 1'b1;
                        state_reg <= ST_LOOP;
                    end else begin
                        window_watchdog_en   <= 1'b1;
                        window_watchdog_long <= 1'b0;
                        window_watchdog_lock <= 1'b1;
                        user_run <= 1'b1;
                    end
                end
                ST_LOOP: begin
                    window_watchdog_en <= 1'b1;
                    loader_window <= 1'b0;
                end
                ST_SAFE: begin
                    safe_mode <= 1'b1;
                    window_watchdog_en <= 1'b1;
                end
                ST_DEBUG, ST_SLEEP: begin
                end
                default: state_reg <= ST_CLASS;
            endcase
        end
    end

    // keys only by loader command in a held-open window (after sync or idle FF)
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            key_write_en   <= 1'b0;
            key_write_mask <= 2'h0;
        end else begin
            key_write_en   <= key_write_cmd && loader_window && forever_reg;
            key_write_mask <= key_write_cmd ? key_write_sel : 2'h0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wd_reset_count <= 3'h0;
        end else begin
            wd_reset_count <= wd_cnt_reg;
        end
    end
endmodule // bss_sequencer

// file: shared/bss_pkg.sv
// constants, states and carriers of the boot startup sequencer
// Overview of operation
// - highest priority reset class runs: cold, warm, hot
// - idle count in 5 ms steps, bad values rejected
// - classify reset from cause register bits
// - watchdog starts long open window while waiting
// - host sync stops watchdog, re-enabled at user
// - watchdog off before entering debug mode
// - watchdog enabled and locked before user code
// - self-test cold only, zero-fill cold and warm; here a hot reset whose self-test runs and passes is zero-filled too
// - config can extend or trim self-test
// - every passing self-test followed by zero-fill; a failing one goes to the loop
// - zero-fill writes zero with good parity
// - test failure: error status, loop, watchdog on
// - five consecutive watchdog resets force sleep; wd_reset_count clears on reset_n here, so the count never passes 1
// - loader size low bits, FF or ECC gives 00
// - mode keys on 3 pages, any exact match
// - keys written only by dedicated loader command
// - keys act only when key switch enabled
// - trim from pages 0,1; CRC fail uses page 2
// - offset calibration only when setting is 01
// - loader boot error: safe mode, sleep after five; the count clears on reset_n here, so sleep_req never rises
// - bad code address, self-test, checksum: endless loop
// - invalid idle count passes FF, latched at reset
// - invalid node address passes FF, latched at reset
package bss_pkg;
    localparam int          CLK_HZ       = 25_000_000;
    localparam int          STEP_MS      = 5;
    localparam int          STEP_CYC     = CLK_HZ / 1000 * STEP_MS;
    localparam int          WD_RST_MAX   = 5;
    localparam int          KEY_PAGES    = 3;
    localparam logic [7:0]  IDLE_NONE    = 8'h00;
    localparam logic [7:0]  IDLE_MIN     = 8'h02;
    localparam logic [7:0]  IDLE_MAX     = 8'h1C;
    localparam logic [7:0]  IDLE_FOREVER = 8'hFF;
    localparam logic [7:0]  NODE_BCAST   = 8'hFF;
    localparam logic [7:0]  SIZE_BLANK   = 8'hFF;
    localparam logic [1:0]  SIZE_DEFAULT = 2'h0;
    localparam logic [7:0]  CAL_ON       = 8'h01;
    localparam logic [31:0] RAM_KEY      = 32'h5A5A_C3C3;
    localparam logic [31:0] MEM_KEY      = 32'hA5A5_3C3C;
    localparam logic [31:0] ADDR_BLANK   = 32'hFFFF_FFFF;
    // self-test config: bit0 warm, bit1 hot, bit2 cold partial
    localparam int          MT_WARM      = 0;
    localparam int          MT_HOT       = 1;
    localparam int          MT_PART      = 2;
    // error status bits
    localparam int          ER_TEST      = 0;
    localparam int          ER_FILL      = 1;
    localparam int          ER_TRIM      = 2;
    localparam int          ER_CSUM      = 3;
    localparam int          ER_ADDR      = 4;
    localparam int          ER_DBE       = 5;

    typedef enum logic [1:0] {BSS_COLD = 2'h0, BSS_WARM = 2'h1, BSS_HOT = 2'h2} bss_class_e;

    typedef enum logic [3:0] {
        ST_CLASS = 4'h0, ST_WDOG = 4'h1, ST_TEST = 4'h3, ST_FILL = 4'h2,
        ST_CFG   = 4'h6, ST_TRIM = 4'h7, ST_CAL  = 4'h5, ST_WIN  = 4'h4,
        ST_HOLD  = 4'hC, ST_USER = 4'hD, ST_DEBUG = 4'hF, ST_LOOP = 4'hE,
        ST_SAFE  = 4'hA, ST_SLEEP = 4'hB
    } bss_state_e;

    // reset cause bits: cold, warm, hot and watchdog sources
    typedef struct packed {
        logic cold;
        logic warm;
        logic hot;
        logic wdog;
    } bss_cause_s;

    // configuration sector contents as read at startup
    typedef struct packed {
        logic [7:0]  idle_count;
        logic        idle_ok;
        logic [7:0]  node_addr;
        logic        node_ok;
        logic [7:0]  loader_size;
        logic        size_ecc2;
        logic [2:0]  test_cfg;
        logic        key_en;
        logic [7:0]  cal_cfg;
        logic        csum_err;
        logic        user_boot;
        logic        debug_req;
        logic [31:0] reset_vec;
    } bss_cfg_s;

    // handshake with a slow engine (self-test, fill, trim, cal)
    typedef struct packed {
        logic done;
        logic fail;
    } bss_ack_s;
endpackage

// file: verif/bss_engine_model.sv
// partner model: slow startup engine answering a start pulse
`timescale 1ns/1ps
module bss_engine_model import bss_pkg::*; (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       start,
    input  wire logic       fail_req,
    input  wire logic [3:0] lat,
    output bss_ack_s        ack
);
    int cnt;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            ack <= '0;
        end else begin
            ack.done <= (cnt == 1);
            // fail means nothing without done, so keep it moving
            ack.fail <= (cnt == 1) ? fail_req : ~ack.fail;
            if (start) cnt <= int'(lat) + 1;
            else if (cnt != 0) cnt <= cnt - 1;
        end
    end
endmodule // bss_engine_model

// file: verif/bss_sequencer_props.sv
// checker: port relations of the startup sequencer
`timescale 1ns/1ps
module bss_sequencer_props import bss_pkg::*; (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire bss_cfg_s   config_sector,
    input wire logic       key_write_cmd,
    input wire logic [1:0] key_write_sel,
    input wire bss_ack_s   test_ack,
    input wire bss_ack_s   trim_ack,
    input wire logic       window_watchdog_en,
    input wire logic       window_watchdog_lock,
    input wire logic       test_start,
    input wire logic       fill_start,
    input wire logic       trim_start,
    input wire logic       trim_backup,
    input wire logic       cal_start,
    input wire logic [1:0] nvm_protect_status,
    input wire logic       key_write_en,
    input wire logic [1:0] key_write_mask,
    input wire logic       loader_window,
    input wire logic       user_run,
    input wire logic       debug_run,
    input wire logic [5:0] error_status,
    input wire bss_class_e reset_class
);
    logic [1:0] exp_size;
    // blank or uncorrectable size falls back to the smallest region
    assign exp_size = (config_sector.loader_size == SIZE_BLANK || config_sector.size_ecc2)
        ? SIZE_DEFAULT : config_sector.loader_size[1:0];
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_user_wdog_lock: assert property (
        user_run |-> window_watchdog_en && window_watchdog_lock) else $error("wd unlocked");
    chk_debug_wdog_off: assert property (
        debug_run |-> !window_watchdog_en) else $error("wd on in debug");
    chk_fill_follows: assert property (
        test_ack.done && !test_ack.fail |-> ##[1:3] fill_start) else $error("no fill");
    chk_test_fail_loop: assert property (
        test_ack.done && test_ack.fail |-> ##[1:3] (error_status[ER_TEST] && window_watchdog_en))
        else $error("test fail unhandled");
    chk_no_test_default: assert property (
        reset_class != BSS_COLD
        && !config_sector.test_cfg[(reset_class == BSS_WARM) ? MT_WARM : MT_HOT]
        |-> !test_start) else $error("unwanted test");
    chk_trim_retry: assert property (
        trim_ack.done && trim_ack.fail && !trim_backup |-> ##[1:3] (trim_start && trim_backup))
        else $error("no backup trim");
    chk_cal_gate: assert property (
        cal_start |-> config_sector.cal_cfg == CAL_ON && reset_class != BSS_HOT)
        else $error("cal not allowed");
    chk_size_load: assert property (
        user_run |-> nvm_protect_status == exp_size) else $error("size wrong");
    chk_steps_first: assert property (
        test_start || fill_start || trim_start || cal_start |-> !loader_window && !user_run)
        else $error("step out of order");
    chk_key_cmd_only: assert property (
        key_write_en |-> $past(key_write_cmd) && key_write_mask == $past(key_write_sel))
        else $error("stray key write");
endmodule // bss_sequencer_props

// file: verif/bss_sequencer_tb_top.sv
// testbench: boots the sequencer over reset classes and configs
`timescale 1ns/1ps
module bss_sequencer_tb_top;
    import bss_pkg::*;
    localparam int SC = 4;
    localparam logic [3:0] CZ [12] = '{8, 4, 2, 14, 1, 2, 8, 8, 4, 8, 8, 4};
    localparam logic [3:0] FZ [12] = '{0, 0, 0, 0, 0, 0, 0, 1, 4, 0, 0, 1};
    logic mclk = 0, reset_n = 0, host_sync = 0, loader_exit = 0, key_write_cmd = 0;
    logic [1:0] key_write_sel = 0;
    logic [3:0] fails = 0, lat = 0;
    bss_cause_s reset_cause_reg = '0;
    bss_cfg_s config_sector = '0;
    logic [31:0] key_page [KEY_PAGES][2];
    bss_ack_s test_ack, fill_ack, trim_ack, cal_ack;
    logic window_watchdog_en, window_watchdog_long, window_watchdog_lock, test_start;
    logic test_partial, fill_start, trim_start, trim_backup, cal_start, ram_mode_on;
    logic mem_mode_on, key_write_en, loader_window, user_run, debug_run, safe_mode, sleep_req;
    logic [1:0] nvm_protect_status, key_write_mask;
    logic [7:0] loader_idle_count, loader_node_addr;
    logic [5:0] error_status;
    logic [2:0] wd_reset_count;
    bss_class_e reset_class;
    int err_total = 0, cmp_count = 0, n_test, n_fill, n_trim, n_cal, n_win;

    bss_sequencer #(.STEP_CYCLES(SC)) dut (.*);
    bss_engine_model u_test (.mclk, .reset_n, .start(test_start), .fail_req(fails[0]),
        .lat, .ack(test_ack));
    bss_engine_model u_fill (.mclk, .reset_n, .start(fill_start), .fail_req(fails[1]),
        .lat, .ack(fill_ack));
    // backup page passes unless told otherwise
    bss_engine_model u_trim (.mclk, .reset_n, .start(trim_start),
        .fail_req(fails[2] & (~trim_backup | fails[3])), .lat, .ack(trim_ack));
    bss_engine_model u_cal (.mclk, .reset_n, .start(cal_start), .fail_req(1'b0),
        .lat, .ack(cal_ack));

    initial begin
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (!reset_n) {n_test, n_fill, n_trim, n_cal, n_win} = '0;
        else begin
            n_test += test_start;
            n_fill += fill_start;
            n_trim += trim_start;
            n_cal += cal_start;
            n_win += loader_window;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        chk(got, exp, what);
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic pulse_key;
        key_write_sel = 2'($urandom);
        key_write_cmd = 1'b1;
        @(negedge mclk);
        key_write_cmd = 1'b0;
    endtask

    task automatic boot(input int hs);
        int t;
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        chk_flag(window_watchdog_en && window_watchdog_long, 1'b1, "long window");
        t = 0;
        while (hs != 0 && loader_window !== 1'b1 && t < 400) begin
            @(negedge mclk);
            t++;
        end
        if (hs != 0) begin
            host_sync = 1'b1;
            @(negedge mclk);
            host_sync = 1'b0;
            repeat (2) @(negedge mclk);
            chk_flag(window_watchdog_en, 1'b0, "wd after sync");
            pulse_key();
            chk_flag(key_write_en, 1'b1, "key write");
            chk(key_write_mask, key_write_sel, "key mask");
            loader_exit = 1'b1;
            @(negedge mclk);
            loader_exit = 1'b0;
        end
        while (user_run !== 1'b1 && debug_run !== 1'b1 && t < 600) begin
            @(negedge mclk);
            t++;
        end
    endtask

    initial begin
        int cls, nt, tf, hs;
        logic ram, mem;
        void'($urandom(32'hFF968C77));
        for (int i = 0; i < 12; i++) begin
            @(negedge mclk);
            reset_n = 1'b0;
            config_sector = '0;
            config_sector.idle_count = IDLE_MIN + 8'($urandom % 27);
            config_sector.idle_ok = 1'b1;
            config_sector.node_addr = 8'($urandom);
            config_sector.node_ok = 1'($urandom);
            config_sector.loader_size = ($urandom % 3 == 0) ? SIZE_BLANK : 8'($urandom);
            config_sector.size_ecc2 = ($urandom % 4 == 0);
            config_sector.test_cfg = 3'($urandom);
            config_sector.key_en = 1'($urandom);
            config_sector.cal_cfg = ($urandom % 2 == 0) ? CAL_ON : 8'($urandom);
            config_sector.user_boot = 1'b1;
            config_sector.reset_vec = 32'h1100_0100;
            foreach (key_page[p]) begin
                key_page[p][0] = ($urandom % 3 == 0) ? RAM_KEY : RAM_KEY ^ (1 << p);
                key_page[p][1] = ($urandom % 3 == 0) ? MEM_KEY : $urandom;
            end
            case (i)
                5: config_sector.idle_ok = 1'b0;
                6: config_sector.idle_count = IDLE_NONE;
                9: config_sector.debug_req = 1'b1;
                10: config_sector.idle_count = IDLE_MAX;
                11: config_sector.test_cfg[MT_WARM] = 1'b1;
                default: ;
            endcase
            reset_cause_reg = bss_cause_s'(CZ[i]);
            fails = FZ[i];
            lat = 4'($urandom % 6);
            hs = (i == 5 || i == 10);
            boot(hs);
            cls = reset_cause_reg.cold || reset_cause_reg.wdog ? 0
                : reset_cause_reg.warm ? 1 : 2;
            nt = (cls == 0) ? 1 : int'(config_sector.test_cfg[cls - 1]);
            tf = fails[0] && nt != 0;
            ram = 1'b0;
            mem = 1'b0;
            foreach (key_page[p]) begin
                ram |= config_sector.key_en && key_page[p][0] == RAM_KEY;
                mem |= config_sector.key_en && key_page[p][1] == MEM_KEY;
            end
            chk(reset_class, cls, "class");
            chk(n_test, nt, "self-test runs");
            chk(n_fill, (tf || (nt == 0 && cls == 2)) ? 0 : 1, "fill runs");
            chk(n_trim, (tf || cls == 2) ? 0 : 1 + fails[2], "trim runs");
            chk(n_cal, !tf && cls < 2 && config_sector.cal_cfg == CAL_ON, "cal");
            chk_flag(test_partial, cls == 0 && config_sector.test_cfg[MT_PART], "part");
            if (tf) begin
                chk_flag(user_run, 1'b0, "left error loop");
                chk_flag(error_status[ER_TEST] && window_watchdog_en, 1'b1, "loop");
            end else if (config_sector.debug_req) begin
                chk_flag(debug_run && !window_watchdog_en, 1'b1, "debug wd");
            end else begin
                chk_flag(window_watchdog_en && window_watchdog_lock, 1'b1, "user wd");
                chk(nvm_protect_status, (config_sector.loader_size == SIZE_BLANK
                    || config_sector.size_ecc2) ? 0 : config_sector.loader_size[1:0],
                    "size");
                chk(loader_idle_count, config_sector.idle_ok ? config_sector.idle_count
                    : IDLE_FOREVER, "idle");
                chk(loader_node_addr, config_sector.node_ok ? config_sector.node_addr
                    : NODE_BCAST, "node");
                chk({ram_mode_on, mem_mode_on}, {ram, mem}, "keys");
                chk_flag(error_status[ER_TRIM], fails[2], "trim error");
                if (hs == 0) chk(n_win, config_sector.idle_count * SC, "window");
                pulse_key();
                chk_flag(key_write_en, 1'b0, "key outside window");
            end
            $display("test %0d done", i);
        end
        tally_and_finish();
    end

    initial begin
        #(40 * 40000);
        err_total++;
        tally_and_finish();
    end
endmodule // bss_sequencer_tb_top

bind bss_sequencer bss_sequencer_props u_props (.*);
